// *** src/swu_pkg.sv ***
// constants, types and decode helpers for the stop-mode wakeup block
package swu_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_A = 8'h00;
  localparam logic [7:0] IDX_KEYPAD_STATUS_CONTROL  = 8'h1A;
  localparam logic [7:0] IDX_KEYPAD_INTERRUPT_ENABLE  = 8'h1B;
  localparam logic [7:0] IDX_CFG2   = 8'h1E;
  localparam logic [7:0] IDX_CFG1   = 8'h1F;

  // field positions
  localparam int WAKE_LATCH_BIT = 6;
  localparam int PEND_FLAG_BIT  = 3;
  localparam int ACK_BIT        = 2;
  localparam int IRQ_MASK_BIT   = 1;
  localparam int WAKE_IE_BIT    = 6;
  localparam int PULLUP_DIS_BIT = 7;
  localparam int IRQ_PIN_EN_BIT = 6;
  localparam int SER_CLK_BIT    = 3;
  localparam int OSC_STOP_BIT   = 1;
  localparam int RST_PIN_BIT    = 0;
  localparam int RATE_SEL_BIT   = 7;
  localparam int SHORT_REC_BIT  = 3;

  // reset values
  localparam logic       RST_BIT_VAL = 1'b0;
  localparam logic [7:0] RST_BYTE    = 8'h00;

  // cycle counts of the fast oscillator clock
  localparam int unsigned REC_SHORT_CYC = 32;
  localparam int unsigned REC_LONG_CYC  = 4096;

  // power sequencing states
  typedef enum logic [1:0] {
    PWR_RUN     = 2'b00,
    PWR_STOP    = 2'b01,
    PWR_RECOVER = 2'b10
  } swu_pwr_type;

  // true when the apb byte address hits the register index
  function automatic logic swu_hit(input logic [7:0] addr, input logic [7:0] idx);
    swu_hit = (addr == {idx[5:0], 2'b00}) && (idx[7:6] == 2'b00);
  endfunction : swu_hit

endpackage : swu_pkg

// *** src/swu_wake_if.sv ***
// link between the wakeup core and its period counter
`timescale 1ns/1ps
interface swu_wake_if;
  logic tick;
  logic run;
  logic restart;
  logic period_short;
  logic overflow;

  modport core    (output tick, output run, output restart, output period_short, input overflow);
  modport counter (input tick, input run, input restart, input period_short, output overflow);
endinterface : swu_wake_if

// *** src/swu_wake_counter.sv ***
// wakeup period counter, clocked by ticks of the selected wakeup clock
`timescale 1ns/1ps
module swu_wake_counter
  import swu_pkg::*;
#(
  parameter int unsigned WAKE_SHORT = 512,
  parameter int unsigned WAKE_LONG  = 16384
) (
  input wire logic pclk,
  input wire logic presetn,
  swu_wake_if.counter wif
);

  logic [14:0] cnt_reg;
  logic        ovf_reg;
  logic [14:0] limit;

  assign limit = wif.period_short ? 15'(WAKE_SHORT - 1) : 15'(WAKE_LONG - 1);

  // counter held at zero while idle, so every stop entry starts fresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 15'h0000;
    end else if (wif.restart || !wif.run) begin
      cnt_reg <= 15'h0000;
    end else if (wif.tick) begin
      cnt_reg <= (cnt_reg == limit) ? 15'h0000 : cnt_reg + 15'h0001;
    end
  end

  // one-cycle overflow pulse in the cycle after the last tick of the period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= wif.run && !wif.restart && wif.tick && (cnt_reg == limit);
    end
  end

  assign wif.overflow = ovf_reg;

  a_count_restart: assert property (@(posedge pclk) disable iff (!presetn)
    wif.restart |=> (cnt_reg == 15'h0000))
    else $error("wakeup counter not cleared on stop entry");

endmodule : swu_wake_counter

// *** src/swu_top.sv ***
// stop-mode wakeup timer with shared keypad interrupt, config and apb slave
//
// Behaviour
// - counter overflow sets the wakeup request latch.
// - latch only sets while wakeup enable is 1; reset clears enable.
// - wakeup uses the keypad interrupt path, no own vector.
// - counters and oscillator idle outside stop mode.
// - with enable set, wakeup starts by itself on stop entry.
// - counters restart from zero at every stop entry.
// - mask bit blocks requests; clear mask lets pending request end stop.
// - latch reads as read-only bit 6 of port A data.
// - upper four status/control bits read zero.
// - read-only pending flag while a request pends; reset clears it.
// - writing 1 to acknowledge clears pending request; reads as 0.
// - oscillator-in-stop 1 keeps bus clock running, clocks wakeup.
// - oscillator-in-stop 0 stops the main clock source in stop.
// - in stop, rate select 1 gives 512, 0 gives 16384 ticks.
// - outside stop, rate select picks watchdog 8176 or 262128 cycles.
// - stop exit delayed 32 fast cycles if short recovery, else 4096.
// - each config register written once per reset, readable always.
// - config registers sit at adjacent fixed addresses 1E and 1F.
// - reset-pin enable cleared only by power-on reset.
// - config bits for pullup disable, irq pin enable, serial clock.
// - oscillator-in-stop 0 clocks wakeup from the dedicated rc oscillator.
// - latch cleared by acknowledge and reset; enable does not hide it.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
module swu_top
  import swu_pkg::*;
#(
  parameter int unsigned WAKE_SHORT_CYC = 512,
  parameter int unsigned WAKE_LONG_CYC  = 16384,
  parameter int unsigned WDOG_SHORT_CYC = 8176,
  parameter int unsigned WDOG_LONG_CYC  = 262128
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_mode,
  input  wire logic        rc_osc_tick,
  input  wire logic        bus_clk_tick,
  input  wire logic        fast_osc_tick,
  input  wire logic        watchdog_service,
  output logic             kbi_irq,
  output logic             stop_wake_req,
  output logic             recovery_busy,
  output logic             main_osc_enable,
  output logic             rc_osc_enable,
  output logic             irq_pullup_disable,
  output logic             irq_pin_enable,
  output logic             serial_clk_sel,
  output logic             reset_pin_enable,
  output logic             watchdog_reset
);

  swu_wake_if wif ();

  // software-visible state
  logic        wake_latch_reg;
  logic        wake_ie_reg;
  logic        irq_mask_reg;
  logic        cfg1_done_reg;
  logic        cfg2_done_reg;
  logic        rate_sel_reg;
  logic        short_rec_reg;
  logic        osc_stop_reg;
  logic        pullup_dis_reg;
  logic        irq_pin_reg;
  logic        ser_clk_reg;
  logic        rst_pin_reg;
  // bus slave
  logic        pready_reg;
  logic        pslverr_reg;
  logic [31:0] prdata_reg;
  logic        access;
  logic        wr_en;
  logic        mapped;
  logic [7:0]  rd_byte;
  logic        ack_wr;
  // sequencing
  swu_pwr_type pwr_state_reg;
  swu_pwr_type pwr_state_next;
  logic [12:0] rec_cnt_reg;
  logic [12:0] rec_limit;
  logic        rec_done;
  logic [17:0] wdog_cnt_reg;
  logic [17:0] wdog_limit;
  logic        stop_entry;
  // outputs
  logic        kbi_irq_reg;
  logic        stop_wake_reg;
  logic        recovery_busy_reg;
  logic        main_osc_reg;
  logic        rc_osc_reg;
  logic        wdog_reset_reg;

  // apb access phase; one wait state so read data comes from a flop
  assign access = psel && penable && !pready_reg;
  assign wr_en  = psel && penable && pready_reg && pwrite;
  assign mapped = swu_hit(paddr, IDX_PORT_A) || swu_hit(paddr, IDX_KEYPAD_STATUS_CONTROL) ||
                  swu_hit(paddr, IDX_KEYPAD_INTERRUPT_ENABLE) || swu_hit(paddr, IDX_CFG2) ||
                  swu_hit(paddr, IDX_CFG1);
  assign ack_wr = wr_en && swu_hit(paddr, IDX_KEYPAD_STATUS_CONTROL) && pwdata[ACK_BIT];

  // read mux; undescribed and port pin bits read as zero
  always_comb begin
    rd_byte = RST_BYTE;
    if (swu_hit(paddr, IDX_PORT_A)) begin
      rd_byte[WAKE_LATCH_BIT] = wake_latch_reg;
    end else if (swu_hit(paddr, IDX_KEYPAD_STATUS_CONTROL)) begin
      rd_byte[PEND_FLAG_BIT] = wake_latch_reg;
      rd_byte[IRQ_MASK_BIT]  = irq_mask_reg;
    end else if (swu_hit(paddr, IDX_KEYPAD_INTERRUPT_ENABLE)) begin
      rd_byte[WAKE_IE_BIT] = wake_ie_reg;
    end else if (swu_hit(paddr, IDX_CFG2)) begin
      rd_byte[PULLUP_DIS_BIT] = pullup_dis_reg;
      rd_byte[IRQ_PIN_EN_BIT] = irq_pin_reg;
      rd_byte[SER_CLK_BIT]    = ser_clk_reg;
      rd_byte[OSC_STOP_BIT]   = osc_stop_reg;
      rd_byte[RST_PIN_BIT]    = rst_pin_reg;
    end else if (swu_hit(paddr, IDX_CFG1)) begin
      rd_byte[RATE_SEL_BIT]  = rate_sel_reg;
      rd_byte[SHORT_REC_BIT] = short_rec_reg;
    end
  end

  // bus handshake, read data and error for unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access;
      pslverr_reg <= access && !mapped;
      prdata_reg  <= (access && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // keypad enable and mask; presetn clears both, por_n alone does not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ie_reg  <= RST_BIT_VAL;
      irq_mask_reg <= RST_BIT_VAL;
    end else begin
      if (wr_en && swu_hit(paddr, IDX_KEYPAD_INTERRUPT_ENABLE)) begin
        wake_ie_reg <= pwdata[WAKE_IE_BIT];
      end
      if (wr_en && swu_hit(paddr, IDX_KEYPAD_STATUS_CONTROL)) begin
        irq_mask_reg <= pwdata[IRQ_MASK_BIT];
      end
    end
  end

  // wakeup request latch; a new overflow beats a same-cycle acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_latch_reg <= 1'b0;
    end else if (wif.overflow && wake_ie_reg) begin
      wake_latch_reg <= 1'b1;
    end else if (ack_wr) begin
      wake_latch_reg <= 1'b0;
    end
  end

  // write-once config 1; a second write is dropped silently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg1_done_reg <= 1'b0;
      rate_sel_reg  <= RST_BIT_VAL;
      short_rec_reg <= RST_BIT_VAL;
    end else if (wr_en && swu_hit(paddr, IDX_CFG1) && !cfg1_done_reg) begin
      cfg1_done_reg <= 1'b1;
      rate_sel_reg  <= pwdata[RATE_SEL_BIT];
      short_rec_reg <= pwdata[SHORT_REC_BIT];
    end
  end

  // write-once config 2, apart from the reset-pin bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg2_done_reg  <= 1'b0;
      osc_stop_reg   <= RST_BIT_VAL;
      pullup_dis_reg <= RST_BIT_VAL;
      irq_pin_reg    <= RST_BIT_VAL;
      ser_clk_reg    <= RST_BIT_VAL;
    end else if (wr_en && swu_hit(paddr, IDX_CFG2) && !cfg2_done_reg) begin
      cfg2_done_reg  <= 1'b1;
      osc_stop_reg   <= pwdata[OSC_STOP_BIT];
      pullup_dis_reg <= pwdata[PULLUP_DIS_BIT];
      irq_pin_reg    <= pwdata[IRQ_PIN_EN_BIT];
      ser_clk_reg    <= pwdata[SER_CLK_BIT];
    end
  end

  // reset-pin bit lives on the power-on reset only, so it survives presetn
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      rst_pin_reg <= RST_BIT_VAL;
    end else if (wr_en && swu_hit(paddr, IDX_CFG2) && !cfg2_done_reg) begin
      rst_pin_reg <= pwdata[RST_PIN_BIT];
    end
  end

  // power sequencing: run, stop, then the recovery delay
  assign stop_entry = stop_mode && (pwr_state_reg != PWR_STOP);
  assign rec_limit  = short_rec_reg ? 13'(REC_SHORT_CYC - 1) : 13'(REC_LONG_CYC - 1);
  assign rec_done   = fast_osc_tick && (rec_cnt_reg == rec_limit);

  always_comb begin
    pwr_state_next = pwr_state_reg;
    unique case (pwr_state_reg)
      PWR_RUN: begin
        if (stop_mode) begin
          pwr_state_next = PWR_STOP;
        end
      end
      PWR_STOP: begin
        if (!stop_mode) begin
          pwr_state_next = PWR_RECOVER;
        end
      end
      PWR_RECOVER: begin
        if (stop_mode) begin
          pwr_state_next = PWR_STOP;
        end else if (rec_done) begin
          pwr_state_next = PWR_RUN;
        end
      end
      default: begin
        pwr_state_next = PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_state_reg <= PWR_RUN;
    end else begin
      pwr_state_reg <= pwr_state_next;
    end
  end

  // recovery delay counted in fast oscillator cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_cnt_reg <= 13'h0000;
    end else if (pwr_state_reg != PWR_RECOVER) begin
      rec_cnt_reg <= 13'h0000;
    end else if (fast_osc_tick) begin
      rec_cnt_reg <= rec_cnt_reg + 13'h0001;
    end
  end

  // watchdog borrows the rate select bit while not stopped
  assign wdog_limit = rate_sel_reg ? 18'(WDOG_SHORT_CYC - 1) : 18'(WDOG_LONG_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cnt_reg   <= 18'h0_0000;
      wdog_reset_reg <= 1'b0;
    end else begin
      wdog_reset_reg <= 1'b0;
      if (stop_mode || watchdog_service) begin
        wdog_cnt_reg <= 18'h0_0000;
      end else if (fast_osc_tick) begin
        if (wdog_cnt_reg == wdog_limit) begin
          wdog_cnt_reg   <= 18'h0_0000;
          wdog_reset_reg <= 1'b1;
        end else begin
          wdog_cnt_reg <= wdog_cnt_reg + 18'h0_0001;
        end
      end
    end
  end

  // wakeup counter runs only in stop with enable set, on the chosen clock
  assign wif.run          = stop_mode && wake_ie_reg;
  assign wif.restart      = stop_entry;
  assign wif.tick         = osc_stop_reg ? bus_clk_tick : rc_osc_tick;
  assign wif.period_short = rate_sel_reg;

  swu_wake_counter #(
    .WAKE_SHORT (WAKE_SHORT_CYC),
    .WAKE_LONG  (WAKE_LONG_CYC)
  ) u_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .wif     (wif)
  );

  // interrupt, wake request and clock enables, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kbi_irq_reg       <= 1'b0;
      stop_wake_reg     <= 1'b0;
      recovery_busy_reg <= 1'b0;
      main_osc_reg      <= 1'b1;
      rc_osc_reg        <= 1'b0;
    end else begin
      kbi_irq_reg       <= wake_latch_reg && !irq_mask_reg;
      stop_wake_reg     <= wake_latch_reg && !irq_mask_reg && stop_mode;
      recovery_busy_reg <= (pwr_state_next == PWR_RECOVER);
      main_osc_reg      <= !stop_mode || osc_stop_reg;
      rc_osc_reg        <= stop_mode && wake_ie_reg && !osc_stop_reg;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  assign kbi_irq            = kbi_irq_reg;
  assign stop_wake_req      = stop_wake_reg;
  assign recovery_busy      = recovery_busy_reg;
  assign main_osc_enable    = main_osc_reg;
  assign rc_osc_enable      = rc_osc_reg;
  assign irq_pullup_disable = pullup_dis_reg;
  assign irq_pin_enable     = irq_pin_reg;
  assign serial_clk_sel     = ser_clk_reg;
  assign reset_pin_enable   = rst_pin_reg;
  assign watchdog_reset     = wdog_reset_reg;

  a_latch_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (wif.overflow && wake_ie_reg) |=> wake_latch_reg)
    else $error("overflow did not set wakeup latch");

  a_latch_gated: assert property (@(posedge pclk) disable iff (!presetn)
    (!wake_latch_reg && !wake_ie_reg) |=> !wake_latch_reg)
    else $error("latch set while enable clear");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (wake_latch_reg && !irq_mask_reg) ##1 (wake_latch_reg && !irq_mask_reg) |-> kbi_irq)
    else $error("shared interrupt missing while pending and unmasked");

  a_idle_outside: assert property (@(posedge pclk) disable iff (!presetn)
    !stop_mode |=> !rc_osc_enable && !wif.overflow)
    else $error("wakeup logic active outside stop");

  a_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (ack_wr && !(wif.overflow && wake_ie_reg)) |=> !wake_latch_reg ##1 !kbi_irq)
    else $error("acknowledge did not clear request");

  a_cfg_once: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg1_done_reg && wr_en && swu_hit(paddr, IDX_CFG1)) |=> $stable(rate_sel_reg) && $stable(short_rec_reg))
    else $error("config register accepted a second write");

  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && $past(swu_hit(paddr, IDX_KEYPAD_STATUS_CONTROL)) && !$past(pwrite)) |-> (prdata[7:4] == 4'h0))
    else $error("status register upper bits not zero");

  a_osc_enable: assert property (@(posedge pclk) disable iff (!presetn)
    (stop_mode && !osc_stop_reg) ##1 (stop_mode && !osc_stop_reg) |-> !main_osc_enable)
    else $error("main oscillator left running in stop");

endmodule : swu_top

// *** test/swu_top_tb_top.sv ***
// self-checking bench for the stop-mode wakeup block
`timescale 1ns/1ps
module swu_top_tb_top;
  import swu_pkg::*;
  logic        pclk, presetn, por_n, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic        pready, pslverr, rd_err, stop_mode, rc_osc_tick, bus_clk_tick, fast_osc_tick;
  logic        watchdog_service, kbi_irq, stop_wake_req, recovery_busy, main_osc_enable, rc_osc_enable;
  logic        irq_pullup_disable, irq_pin_enable, serial_clk_sel, reset_pin_enable, watchdog_reset;
  logic [31:0] seed = 32'h2346;
  int          bad_count, compares, wd_seen;

  // wakeup long and both watchdog counts shortened so the run stays brief
  swu_top #(.WAKE_LONG_CYC(64), .WDOG_SHORT_CYC(40), .WDOG_LONG_CYC(80)) swu_top_i (
    .pclk, .presetn, .por_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .stop_mode, .rc_osc_tick, .bus_clk_tick, .fast_osc_tick, .watchdog_service,
    .kbi_irq, .stop_wake_req, .recovery_busy, .main_osc_enable, .rc_osc_enable,
    .irq_pullup_disable, .irq_pin_enable, .serial_clk_sel, .reset_pin_enable, .watchdog_reset);

  // xorshift source, fixed start so runs repeat
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected counts, mirroring the shortened parameters
  function automatic int wake_n(input logic r);
    return r ? 512 : 64;
  endfunction : wake_n

  function automatic int rec_n(input logic s);
    return s ? 32 : 4096;
  endfunction : rec_n

  function automatic int wd_n(input logic r);
    return r ? 40 : 80;
  endfunction : wd_n

  function automatic logic [7:0] adr(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : adr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chb

  // wait n edges, then look at outputs mid-cycle where they are settled
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // one apb transfer; answer taken at the edge that samples pready high, hang guard ends a lost answer
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= adr(idx);
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd_data, exp);
    chb(rd_err, 1'b0);
  endtask : rd

  // ticks of one source (0 rc, 1 bus, 2 fast); the other slow source jitters as noise
  // at least one edge before each tick, so it is driven on a rising edge and never twice in one step
  task automatic pulse(input int src, input int n);
    logic [31:0] r;
    repeat (n) begin
      r = rnd();
      repeat (int'(r[2:1]) + 1) @(posedge pclk);
      rc_osc_tick   <= (src == 0) | ((src == 1) & r[0]);
      bus_clk_tick  <= (src == 1) | ((src == 0) & r[0]);
      fast_osc_tick <= (src == 2);
      @(posedge pclk);
      {rc_osc_tick, bus_clk_tick, fast_osc_tick} <= 3'b000;
    end
  endtask : pulse

  task automatic set_stop(input logic v);
    @(posedge pclk);
    stop_mode <= v;
    settle(1);
  endtask : set_stop

  // service held so recovery ticks do not feed the watchdog
  task automatic recov(input logic s);
    @(posedge pclk);
    stop_mode        <= 1'b0;
    watchdog_service <= 1'b1;
    pulse(2, rec_n(s) - 1);
    settle(1);
    chb(recovery_busy, 1'b1);
    pulse(2, 1);
    settle(3);
    chb(recovery_busy, 1'b0);
    @(posedge pclk);
    watchdog_service <= 1'b0;
  endtask : recov

  task automatic wdog(input logic r);
    wd_seen = 0;
    pulse(2, wd_n(r) - 1);
    settle(3);
    chk(wd_seen, 0);
    pulse(2, 1);
    settle(3);
    chk(wd_seen, 1);
  endtask : wdog

  // one configuration pass: write-once config, idle stop, wakeup, mask, ack, recovery
  task automatic round(input logic [7:0] c2, input logic [7:0] c1);
    int src;
    int n;
    src = int'(c2[OSC_STOP_BIT]);
    n   = wake_n(c1[RATE_SEL_BIT]);
    wr(IDX_CFG2, {24'h0, c2});
    wr(IDX_CFG2, {24'h0, ~c2});
    rd(IDX_CFG2, {24'h0, c2 & 8'hCB});
    wr(IDX_CFG1, {24'h0, c1});
    wr(IDX_CFG1, {24'h0, ~c1});
    rd(IDX_CFG1, {24'h0, c1 & 8'h88});
    chk({28'h0, irq_pullup_disable, irq_pin_enable, serial_clk_sel, reset_pin_enable}, 32'({c2[7:6], c2[3], c2[0]}));
    set_stop(1'b1);
    chb(main_osc_enable, c2[OSC_STOP_BIT]);
    chb(rc_osc_enable, 1'b0);
    pulse(src, n);
    settle(4);
    rd(IDX_PORT_A, 32'h0000_0000);
    recov(c1[SHORT_REC_BIT]);
    chb(main_osc_enable, 1'b1);
    wr(IDX_KEYPAD_INTERRUPT_ENABLE, rnd() | 32'h0000_0040);
    rd(IDX_KEYPAD_INTERRUPT_ENABLE, 32'h0000_0040);
    set_stop(1'b1);
    chb(rc_osc_enable, !c2[OSC_STOP_BIT]);
    pulse(src, n / 2);
    set_stop(1'b0);
    set_stop(1'b1);
    pulse(src, n - 1);
    settle(4);
    chb(kbi_irq, 1'b0);
    rd(IDX_PORT_A, 32'h0000_0000);
    pulse(src, 1);
    settle(4);
    chb(kbi_irq, 1'b1);
    chb(stop_wake_req, 1'b1);
    rd(IDX_PORT_A, 32'h0000_0040);
    rd(IDX_KEYPAD_STATUS_CONTROL, 32'h0000_0008);
    wr(IDX_KEYPAD_STATUS_CONTROL, 32'h0000_00F2);
    settle(2);
    chb(kbi_irq, 1'b0);
    chb(stop_wake_req, 1'b0);
    rd(IDX_KEYPAD_STATUS_CONTROL, 32'h0000_000A);
    wr(IDX_KEYPAD_STATUS_CONTROL, 32'h0000_0006);
    rd(IDX_KEYPAD_STATUS_CONTROL, 32'h0000_0002);
    rd(IDX_PORT_A, 32'h0000_0000);
    wr(IDX_KEYPAD_STATUS_CONTROL, 32'h0000_0000);
    recov(c1[SHORT_REC_BIT]);
    wdog(c1[RATE_SEL_BIT]);
  endtask : round

  task automatic summarize();
    $display("TB: checks=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize

  // free-running clock, 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // watchdog pulses counted as they appear
  always @(posedge pclk) begin
    if (watchdog_reset === 1'b1) wd_seen++;
  end

  // hang guard, well above the expected run length
  initial begin
    repeat (80000) @(posedge pclk);
    bad_count++;
    summarize();
  end

  // main sequence: reset values, two config passes with a plain reset between
  initial begin
    logic [7:0] regs [5];
    regs = '{IDX_PORT_A, IDX_KEYPAD_STATUS_CONTROL, IDX_KEYPAD_INTERRUPT_ENABLE, IDX_CFG2, IDX_CFG1};
    {presetn, por_n, psel, penable, pwrite, stop_mode} = '0;
    {rc_osc_tick, bus_clk_tick, fast_osc_tick, watchdog_service} = '0;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(regs[i], 32'h0000_0000);
    end
    apb(1'b0, 8'h01, 32'h0000_0000);
    chb(rd_err, 1'b1);
    chk(rd_data, 32'h0000_0000);
    chb(main_osc_enable, 1'b1);
    round(8'hCB, 8'h00);
    @(posedge pclk);
    presetn <= 1'b0;
    settle(2);
    chb(reset_pin_enable, 1'b1);
    chb(kbi_irq, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(IDX_CFG2, 32'h0000_0001);
    rd(IDX_KEYPAD_INTERRUPT_ENABLE, 32'h0000_0000);
    round(8'h00, 8'h88);
    summarize();
  end
endmodule : swu_top_tb_top
